// file: rtl/aefl_cfg.svh
// Offsets, field positions and reset values of the attention and event-flag logic.
`ifndef AEFL_CFG_SVH
`define AEFL_CFG_SVH
`define AEFL_ADDR_SRC_EN      8'h16
`define AEFL_ADDR_PIN_CFG     8'h17
`define AEFL_ADDR_COMBINED    8'h18
`define AEFL_ADDR_HIGH        8'h1A
`define AEFL_ADDR_LOW         8'h1C
`define AEFL_ADDR_REGION      8'h1E
`define AEFL_ADDR_CH_MASK     8'h14
`define AEFL_BIT_CRC_EN       0
`define AEFL_BIT_RMS_EN       1
`define AEFL_BIT_DRIVE        2
`define AEFL_LOGIC_LSB        0
`define AEFL_LOGIC_MSB        1
`define AEFL_SRC_EN_MASK      8'h03
`define AEFL_PIN_CFG_MASK     8'h07
`define AEFL_RESET_BYTE       8'h00
`define AEFL_PULSE_CYCLES     4'h4
`endif

// file: rtl/aefl_pkg.sv
// Types shared by the attention and event-flag logic.
package aefl_pkg;
	typedef enum logic [1:0] {AEFL_LOW_LEVEL, AEFL_HIGH_LEVEL, AEFL_LOW_PULSE,
		AEFL_HIGH_PULSE} aefl_style_type;
	typedef enum {AEFL_IDLE, AEFL_PULSE} aefl_state_type;
endpackage

// file: rtl/aefl_alert_event_flag_logic.sv
// Attention output and event-flag registers of the eight-channel monitor.
`timescale 1ns/10ps
`include "aefl_cfg.svh"
module aefl_alert_event_flag_logic
	import aefl_pkg::*;
#(
	parameter int CHANNELS = 8
)
(
	// Clock and reset.
	input  wire logic                clk,
	input  wire logic                reset_n,
	// Register port from the serial interface.
	input  wire logic                regWrite,
	input  wire logic [7:0]          regAddr,
	input  wire logic [7:0]          regWdata,
	output logic      [7:0]          regRdata,
	// Per-channel comparator results, same clock domain.
	input  wire logic [CHANNELS-1:0] aboveHigh,
	input  wire logic [CHANNELS-1:0] belowLow,
	input  wire logic [CHANNELS-1:0] insideWindow,
	input  wire logic [CHANNELS-1:0] digitalMode,
	input  wire logic [CHANNELS-1:0] digitalLevel,
	input  wire logic [CHANNELS-1:0] sampleValid,
	// Other notification sources, levels held by their owners.
	input  wire logic                rmsCompleteFlag,
	input  wire logic                inputCrcErrorFlag,
	// Attention pin.
	output logic                     alertOut,
	output logic                     alertOe_n
);
	logic [7:0]          srcEnable_r, srcEnable_nxt;
	logic [7:0]          pinCfg_r, pinCfg_nxt;
	logic [7:0]          chMask_r, chMask_nxt;
	logic [7:0]          region_r, region_nxt;
	logic [CHANNELS-1:0] highFlags_r, highFlags_nxt;
	logic [CHANNELS-1:0] lowFlags_r, lowFlags_nxt;
	logic [CHANNELS-1:0] highSet, lowSet, highClr, lowClr, combined;
	logic [CHANNELS-1:0] pendCh_r;
	logic                rmsPrev_r, crcPrev_r;
	logic                pending;
	logic                newFlag;
	logic [3:0]          pulseCnt_r, pulseCnt_nxt;
	logic [3:0]          queued_r, queued_nxt;
	aefl_state_type      state_r, state_nxt;
	aefl_style_type      style;
	logic                active;
	logic                level;

	assign style = aefl_style_type'(pinCfg_r[`AEFL_LOGIC_MSB:`AEFL_LOGIC_LSB]);

	// Per-channel set terms; a digital input follows the region polarity.
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : gChan
			always_comb
			begin
				if (digitalMode[g])
				begin
					highSet[g] = sampleValid[g] & (digitalLevel[g] ^ region_r[g]);
					lowSet[g]  = sampleValid[g] & ~(digitalLevel[g] ^ region_r[g]);
				end
				else if (region_r[g])
				begin
					highSet[g] = sampleValid[g] & insideWindow[g];
					lowSet[g]  = sampleValid[g] & insideWindow[g];
				end
				else
				begin
					highSet[g] = sampleValid[g] & aboveHigh[g];
					lowSet[g]  = sampleValid[g] & belowLow[g];
				end
			end
		end
	endgenerate

	assign highClr = (regWrite && regAddr == `AEFL_ADDR_HIGH) ? regWdata[CHANNELS-1:0] : '0;
	assign lowClr  = (regWrite && regAddr == `AEFL_ADDR_LOW) ? regWdata[CHANNELS-1:0] : '0;
	assign combined = highFlags_r | lowFlags_r;

	always_comb
	begin
		srcEnable_nxt = srcEnable_r;
		pinCfg_nxt    = pinCfg_r;
		chMask_nxt    = chMask_r;
		region_nxt    = region_r;
		// Set wins over clear so no event is lost.
		highFlags_nxt = (highFlags_r & ~highClr) | highSet;
		lowFlags_nxt  = (lowFlags_r & ~lowClr) | lowSet;
		if (regWrite)
		begin
			if (regAddr == `AEFL_ADDR_SRC_EN)
				srcEnable_nxt = regWdata & `AEFL_SRC_EN_MASK;
			else if (regAddr == `AEFL_ADDR_PIN_CFG)
				pinCfg_nxt = regWdata & `AEFL_PIN_CFG_MASK;
			else if (regAddr == `AEFL_ADDR_CH_MASK)
				chMask_nxt = regWdata;
			else if (regAddr == `AEFL_ADDR_REGION)
				region_nxt = regWdata;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			srcEnable_r <= `AEFL_RESET_BYTE;
			pinCfg_r    <= `AEFL_RESET_BYTE;
			chMask_r    <= `AEFL_RESET_BYTE;
			region_r    <= `AEFL_RESET_BYTE;
			highFlags_r <= '0;
			lowFlags_r  <= '0;
		end
		else
		begin
			srcEnable_r <= srcEnable_nxt;
			pinCfg_r    <= pinCfg_nxt;
			chMask_r    <= chMask_nxt;
			region_r    <= region_nxt;
			highFlags_r <= highFlags_nxt;
			lowFlags_r  <= lowFlags_nxt;
		end
	end

	// Read mux; the combined register has no write path at all.
	always_comb
	begin
		if (regAddr == `AEFL_ADDR_SRC_EN)
			regRdata = srcEnable_r;
		else if (regAddr == `AEFL_ADDR_PIN_CFG)
			regRdata = pinCfg_r;
		else if (regAddr == `AEFL_ADDR_COMBINED)
			regRdata = 8'(combined);
		else if (regAddr == `AEFL_ADDR_HIGH)
			regRdata = 8'(highFlags_r);
		else if (regAddr == `AEFL_ADDR_LOW)
			regRdata = 8'(lowFlags_r);
		else if (regAddr == `AEFL_ADDR_REGION)
			regRdata = region_r;
		else if (regAddr == `AEFL_ADDR_CH_MASK)
			regRdata = chMask_r;
		else
			regRdata = `AEFL_RESET_BYTE;
	end

	// Pending sources and rising edges of each source for pulsed styles.
	assign pending = |(combined & chMask_r[CHANNELS-1:0])
		| (srcEnable_r[`AEFL_BIT_RMS_EN] & rmsCompleteFlag)
		| (srcEnable_r[`AEFL_BIT_CRC_EN] & inputCrcErrorFlag);
	assign newFlag = |(combined & ~pendCh_r & chMask_r[CHANNELS-1:0])
		| (srcEnable_r[`AEFL_BIT_RMS_EN] & rmsCompleteFlag & ~rmsPrev_r)
		| (srcEnable_r[`AEFL_BIT_CRC_EN] & inputCrcErrorFlag & ~crcPrev_r);

	// One pulse per cycle with a new flag; flags arriving during a pulse are queued, up to 15, not merged.
	always_comb
	begin
		state_nxt    = state_r;
		pulseCnt_nxt = pulseCnt_r;
		queued_nxt   = queued_r;
		if (newFlag && queued_r != 4'hF)
			queued_nxt = queued_r + 4'h1;
		case (state_r)
			AEFL_IDLE:
			begin
				if (queued_r != 4'h0)
				begin
					state_nxt    = AEFL_PULSE;
					pulseCnt_nxt = `AEFL_PULSE_CYCLES;
					queued_nxt   = queued_nxt - 4'h1;
				end
			end
			AEFL_PULSE:
			begin
				pulseCnt_nxt = pulseCnt_r - 4'h1;
				if (pulseCnt_r == 4'h1)
					state_nxt = AEFL_IDLE;
			end
			default: state_nxt = AEFL_IDLE;
		endcase
		if (style == AEFL_LOW_LEVEL || style == AEFL_HIGH_LEVEL)
		begin
			state_nxt  = AEFL_IDLE;
			queued_nxt = 4'h0;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r    <= AEFL_IDLE;
			pulseCnt_r <= 4'h0;
			queued_r   <= 4'h0;
			pendCh_r   <= '0;
			rmsPrev_r  <= 1'b0;
			crcPrev_r  <= 1'b0;
		end
		else
		begin
			state_r    <= state_nxt;
			pulseCnt_r <= pulseCnt_nxt;
			queued_r   <= queued_nxt;
			pendCh_r   <= combined & chMask_r[CHANNELS-1:0];
			rmsPrev_r  <= srcEnable_r[`AEFL_BIT_RMS_EN] & rmsCompleteFlag;
			crcPrev_r  <= srcEnable_r[`AEFL_BIT_CRC_EN] & inputCrcErrorFlag;
		end
	end

	assign active = (style == AEFL_LOW_LEVEL || style == AEFL_HIGH_LEVEL) ? pending
		: (state_r == AEFL_PULSE);
	// Style bit zero selects the active-high polarity.
	assign level = active ? style[0] : ~style[0];
	// Open-drain only ever pulls low, so a high level there is left to the pullup.
	assign alertOut  = level;
	assign alertOe_n = pinCfg_r[`AEFL_BIT_DRIVE] ? 1'b0 : level;

	a_rms_asserts: assert property (@(posedge clk) disable iff (!reset_n)
		(style == AEFL_LOW_LEVEL && srcEnable_r[`AEFL_BIT_RMS_EN] && rmsCompleteFlag)
		|-> (alertOut == 1'b0 && alertOe_n == 1'b0))
		else $error("RMS flag did not assert attention.");
	a_crc_asserts: assert property (@(posedge clk) disable iff (!reset_n)
		(style == AEFL_HIGH_LEVEL && srcEnable_r[`AEFL_BIT_CRC_EN] && inputCrcErrorFlag)
		|-> alertOut)
		else $error("CRC flag did not assert attention.");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
		((srcEnable_r & ~`AEFL_SRC_EN_MASK) == 8'h00)
		&& ((pinCfg_r & ~`AEFL_PIN_CFG_MASK) == 8'h00))
		else $error("Reserved bit read nonzero.");
	a_push_pull: assert property (@(posedge clk) disable iff (!reset_n)
		pinCfg_r[`AEFL_BIT_DRIVE] |-> !alertOe_n)
		else $error("Push-pull pin not driven.");
	a_open_drain: assert property (@(posedge clk) disable iff (!reset_n)
		(!pinCfg_r[`AEFL_BIT_DRIVE] && !alertOe_n) |-> !alertOut)
		else $error("Open-drain pin drove high.");
	a_idle_level: assert property (@(posedge clk) disable iff (!reset_n)
		(style == AEFL_HIGH_LEVEL && !pending) |-> !alertOut)
		else $error("Attention active with nothing pending.");
	a_pulse_width: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(state_r == AEFL_PULSE) |-> (state_r == AEFL_PULSE) [*4] ##1 state_r == AEFL_IDLE)
		else $error("Attention pulse has wrong width.");
	a_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
		(highSet[0] && highClr[0]) |=> highFlags_r[0])
		else $error("Clear won over a set.");
	a_write_one: assert property (@(posedge clk) disable iff (!reset_n)
		(lowClr[0] && !lowSet[0]) |=> !lowFlags_r[0])
		else $error("Write one did not clear flag.");
	a_mask_gate: assert property (@(posedge clk) disable iff (!reset_n)
		(style == AEFL_HIGH_LEVEL && srcEnable_r == 8'h00 && chMask_r == 8'h00) |-> !alertOut)
		else $error("Unselected channel asserted attention.");
endmodule

// file: verification/aefl_host_pin.sv
// Host-side model of the attention line with its external pull-up.
`timescale 1ns/10ps
module aefl_host_pin
(
	// Pin as driven by the device.
	input  wire logic alertOut,
	input  wire logic alertOe_n,
	// Level the host sees on the line.
	output logic      pinLevel
);
	// A released pin is pulled up, so an undriven line never reads as a stale value.
	assign pinLevel = alertOe_n ? 1'b1 : alertOut;
endmodule

// file: verification/aefl_alert_event_flag_logic_test.sv
// Self-checking bench of the attention and event-flag logic.
`timescale 1ns/10ps
module aefl_alert_event_flag_logic_test;
	logic       clk;
	logic       reset_n;
	logic       regWrite;
	logic [7:0] regAddr;
	logic [7:0] regWdata;
	logic [7:0] regRdata;
	logic [7:0] ah, bl, iw, dm, dl, sv;
	logic [1:0] src;
	logic       alertOut;
	logic       alertOe_n;
	logic       pinLevel;
	int         errors;
	int         samples_checked;
	int         i;
	int         n;
	logic [7:0] adr [8] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1A, 8'h1C, 8'h1E};

	aefl_alert_event_flag_logic aefl_alert_event_flag_logic_inst (.clk(clk),
		.reset_n(reset_n), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata), .aboveHigh(ah), .belowLow(bl), .insideWindow(iw),
		.digitalMode(dm), .digitalLevel(dl), .sampleValid(sv), .rmsCompleteFlag(src[1]),
		.inputCrcErrorFlag(src[0]), .alertOut(alertOut), .alertOe_n(alertOe_n));
	aefl_host_pin aefl_host_pin_inst (.alertOut(alertOut), .alertOe_n(alertOe_n),
		.pinLevel(pinLevel));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		regAddr = a;
		regWdata = d;
		regWrite = 1'b1;
		@(negedge clk);
		regWrite = 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		regAddr = a;
		#1;
		chk(regRdata, e);
	endtask

	task pin(input logic e);
		@(negedge clk);
		#1;
		chk({7'h00, pinLevel}, {7'h00, e});
	endtask

	task smp(input logic [7:0] v, input logic [7:0] h, input logic [7:0] l,
		input logic [7:0] w, input logic [7:0] d);
		@(negedge clk);
		sv = v;
		ah = h;
		bl = l;
		iw = w;
		dl = d;
		@(negedge clk);
		sv = 8'h00;
	endtask

	task final_report;
		$display("checks %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Far longer than the tests take, so only a hang reaches it.
	initial
	begin
		#100000;
		$display("wrong value at %0t: watchdog expired", $time);
		errors++;
		final_report;
	end

	initial
	begin
		{regWrite, regAddr, regWdata, ah, bl, iw, dm, dl, sv, src} = '0;
		errors = 0;
		samples_checked = 0;
		reset_n = 1'b0;
		repeat (16) @(negedge clk);
		reset_n = 1'b1;
		for (i = 0; i < 8; i++)
			rd(adr[i], 8'h00);
		pin(1'b1);
		wr(8'h16, 8'hFF);
		rd(8'h16, 8'h03);
		wr(8'h17, 8'hFF);
		rd(8'h17, 8'h07);
		wr(8'h17, 8'h00);
		wr(8'h16, 8'h00);
		$display("test reserved finished");
		smp(8'h01, 8'h01, 8'h00, 8'h00, 8'h00);
		smp(8'h01, 8'h00, 8'h01, 8'h00, 8'h00);
		rd(8'h1A, 8'h01);
		rd(8'h1C, 8'h01);
		wr(8'h18, 8'hFF);
		rd(8'h18, 8'h01);
		pin(1'b1);
		wr(8'h14, 8'h01);
		pin(1'b0);
		wr(8'h1A, 8'h00);
		rd(8'h1A, 8'h01);
		wr(8'h1A, 8'h01);
		rd(8'h1A, 8'h00);
		rd(8'h18, 8'h01);
		wr(8'h1C, 8'h01);
		rd(8'h18, 8'h00);
		pin(1'b1);
		$display("test analog flags finished");
		dm = 8'h06;
		wr(8'h1E, 8'h0C);
		smp(8'h06, 8'h00, 8'h00, 8'h00, 8'h02);
		rd(8'h1A, 8'h06);
		rd(8'h1C, 8'h00);
		smp(8'h0E, 8'h00, 8'h00, 8'h08, 8'h04);
		rd(8'h1C, 8'h0E);
		rd(8'h1A, 8'h0E);
		wr(8'h1A, 8'hFF);
		wr(8'h1C, 8'hFF);
		@(negedge clk);
		regAddr = 8'h1A;
		regWdata = 8'h01;
		regWrite = 1'b1;
		sv = 8'h01;
		ah = 8'h01;
		@(negedge clk);
		regWrite = 1'b0;
		sv = 8'h00;
		rd(8'h1A, 8'h01);
		wr(8'h1A, 8'hFF);
		$display("test region and digital finished");
		for (i = 0; i < 2; i++)
		begin
			src = 2'b01 << i;
			pin(1'b1);
			wr(8'h16, 8'h01 << i);
			pin(1'b0);
			src = 2'b00;
			pin(1'b1);
		end
		src = 2'b10;
		wr(8'h17, 8'h05);
		rd(8'h17, 8'h05);
		chk({6'h00, alertOut, alertOe_n}, 8'h02);
		src = 2'b00;
		pin(1'b0);
		wr(8'h16, 8'h00);
		smp(8'h02, 8'h00, 8'h00, 8'h00, 8'h00);
		rd(8'h18, 8'h02);
		pin(1'b0);
		wr(8'h1C, 8'hFF);
		wr(8'h16, 8'h02);
		$display("test sources and levels finished");
		for (i = 2; i < 4; i++)
		begin
			wr(8'h17, 8'h04 | i[7:0]);
			@(negedge clk);
			src = 2'b10;
			n = 0;
			repeat (14) @(negedge clk) if (alertOut === i[0]) n++;
			chk(n[7:0], 8'h04);
			src = 2'b00;
		end
		$display("test pulses finished");
		final_report;
	end
endmodule
